// [design/vc_cap_pkg.sv]
// package for the virtual channel capability register bank
// assumes a plain register port with byte addresses inside the configuration space
package vc_cap_pkg;

    // ----------------------------------------
    // bus widths and register offsets
    // ----------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFS_CAP_ONE = 12'h204; // port_vc_capability_one
    localparam logic [11:0] OFS_CAP_TWO = 12'h208; // port_vc_capability_two
    localparam logic [11:0] OFS_CTL = 12'h20c; // port_vc_control_word
    localparam logic [11:0] OFS_STS = 12'h20e; // port_vc_status_word
    localparam logic [11:0] OFS_VCR0 = 12'h210; // vc_resource0_capability

    // ----------------------------------------
    // field positions and widths
    // ----------------------------------------
    localparam int EXTRA_LSB = 0;
    localparam int EXTRA_W = 3;
    localparam int LOWPRI_LSB = 4;
    localparam int LOWPRI_W = 3;
    localparam int TBASE_LSB = 8;
    localparam int TBASE_W = 2;
    localparam int ESIZE_LSB = 10;
    localparam int ESIZE_W = 2;
    localparam int CARB_CAP_LSB = 0;
    localparam int CARB_CAP_W = 8;
    localparam int CARB_OFS_LSB = 24;
    localparam int CARB_OFS_W = 8;
    localparam int LOAD_BIT = 0;
    localparam int SEL_LSB = 1;
    localparam int SEL_W = 3;
    localparam int TSTAT_BIT = 0;
    localparam int PARB_LSB = 0;
    localparam int PARB_W = 8;
    localparam int SNOOP_BIT = 15;
    localparam int MAX_TIME_SLOTS_LSB = 16;
    localparam int MAX_TIME_SLOTS_W = 7;
    localparam int PATOFF_LSB = 24;
    localparam int PATOFF_W = 8;
    localparam int HALF_W = 16;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [2:0] EXTRA_RST = 3'h0;
    localparam logic [2:0] LOWPRI_RST = 3'h0;
    localparam logic [1:0] ESIZE_RST = 2'h2;
    localparam logic [7:0] PARB_RST = 8'h01;
    localparam logic [7:0] PATOFF_RST = 8'h04;
    localparam logic [0:0] LOAD_RST = 1'h0;
    localparam logic [2:0] SEL_RST = 3'h0;

    // ----------------------------------------
    // encodings
    // ----------------------------------------
    localparam logic [1:0] ESIZE_1BIT = 2'h0;
    localparam logic [1:0] ESIZE_2BIT = 2'h1;
    localparam logic [1:0] ESIZE_4BIT = 2'h2;
    localparam logic [1:0] ESIZE_8BIT = 2'h3;
    localparam int PARB_HW_FIXED_BIT = 0;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic [11:0] addr; // byte address
        logic [31:0] wdata; // write data
        logic wr; // write strobe
        logic rd; // read strobe
        logic priv; // privileged or initialization access
    } cfg_req_t;

    typedef struct packed {
        logic [7:0] table_offset; // port table offset in 16-byte units
        logic [1:0] entry_size; // port table entry size code
        logic [7:0] capability; // port arbitration capability bits
    } arb_info_t;

endpackage : vc_cap_pkg

// [design/field_reg.sv]
// one stored configuration field with its own write enable and reset value
// assumes a single clock and a synchronous active high reset
`timescale 1ns/10ps
module field_reg #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_sys, // system clock
    input wire logic reset, // synchronous reset, active high
    input wire logic wr_en, // load strobe
    input wire logic [W-1:0] wr_data, // value to load
    output logic [W-1:0] q // stored field
);

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    // next value: keep unless loaded
    assign q_nxt = wr_en ? wr_data : q_r;

    // field flop
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q_r <= RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule : field_reg

// [design/read_port.sv]
// registered read data for the configuration port
// assumes the read strobe is one cycle long and the word is already selected
`timescale 1ns/10ps
module read_port (
    input wire logic clk_sys, // system clock
    input wire logic reset, // synchronous reset, active high
    input wire logic rd_en, // read strobe
    input wire logic [31:0] rd_word, // selected word
    output logic [31:0] rdata // read data, valid one cycle after the strobe
);

    // ----------------------------------------
    // read data register
    // ----------------------------------------
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // data stand only in the cycle after the strobe, zero otherwise
    assign rdata_nxt = rd_en ? rd_word : 32'h0000_0000;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

endmodule : read_port

// [design/vc_capability_regs.sv]
// register bank of a switch port's virtual channel capability structure
// assumes a plain register port on clk_sys, one-cycle strobes, read data one cycle later
//
// Overview of operation
// - the extended channel count is a three-bit field at bits 2:0 that resets to zero, so only VC0 exists.
// - the low priority channel count at bits 6:4 resets to zero and changes only on a privileged write.
// - the time base select field at bits 9:8 always reads zero.
// - the table entry size at bits 11:10 resets to 0x2 for 4-bit entries, codes 0 to 3 meaning 1, 2, 4, 8 bits.
// - the channel arbitration capability byte at bits 7:0 of the second capability word reads zero.
// - the channel arbitration table offset at bits 31:24 of the second capability word reads zero.
// - the load channel table bit 0 of the control word is writable, resets to zero and does nothing.
// - the channel arbitration select at bits 3:1 of the control word is stored, resets to zero, and steers nothing.
// - the channel table status bit 0 of the status word reads zero.
// - the port arbitration capability byte resets to 0x1, bit 0 meaning hardware fixed arbitration.
// - the reject snoop bit 15 of the resource capability reads zero.
// - the maximum time slots field at bits 22:16 reads zero.
// - the port arbitration table offset at bits 31:24 resets to 0x4, counted in 16-byte units.
`timescale 1ns/10ps
module vc_capability_regs (
    input wire logic clk_sys, // system clock, 100 MHz
    input wire logic reset, // synchronous reset, active high
    input wire vc_cap_pkg::cfg_req_t req, // register access request
    output logic [31:0] rdata, // read data, one cycle after the read strobe
    output vc_cap_pkg::arb_info_t arb_info, // port arbitration table info
    output logic [2:0] channel_arb_select // stored select value, no effect
);

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    logic hit_cap_one;
    logic hit_cap_two;
    logic hit_ctl;
    logic hit_sts;
    logic hit_vcr0;
    logic hit_any;
    logic wr_priv;
    logic wr_cap_one_lock;
    logic wr_vcr0_lock;
    logic wr_ctl;

    // one compare per register
    assign hit_cap_one = (req.addr == vc_cap_pkg::OFS_CAP_ONE);
    assign hit_cap_two = (req.addr == vc_cap_pkg::OFS_CAP_TWO);
    assign hit_ctl = (req.addr == vc_cap_pkg::OFS_CTL);
    assign hit_sts = (req.addr == vc_cap_pkg::OFS_STS);
    assign hit_vcr0 = (req.addr == vc_cap_pkg::OFS_VCR0);
    assign hit_any = hit_cap_one | hit_cap_two | hit_ctl | hit_sts | hit_vcr0;

    // lockable fields only take privileged writes
    assign wr_priv = req.wr & req.priv;
    assign wr_cap_one_lock = wr_priv & hit_cap_one;
    assign wr_vcr0_lock = wr_priv & hit_vcr0;

    // control word takes any write
    assign wr_ctl = req.wr & hit_ctl;

    // ----------------------------------------
    // capability one fields
    // ----------------------------------------
    logic [2:0] extra_channel_count;
    logic [2:0] low_priority_channel_count;
    logic [1:0] arb_table_entry_size;

    // extended channel count, zero means VC0 only
    field_reg #(
        .W(vc_cap_pkg::EXTRA_W),
        .RST(vc_cap_pkg::EXTRA_RST)
    ) u_extra (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(wr_cap_one_lock),
        .wr_data(req.wdata[vc_cap_pkg::EXTRA_LSB +: vc_cap_pkg::EXTRA_W]),
        .q(extra_channel_count)
    );

    // low priority count, zero out of reset and to ordinary software
    field_reg #(
        .W(vc_cap_pkg::LOWPRI_W),
        .RST(vc_cap_pkg::LOWPRI_RST)
    ) u_lowpri (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(wr_cap_one_lock),
        .wr_data(req.wdata[vc_cap_pkg::LOWPRI_LSB +: vc_cap_pkg::LOWPRI_W]),
        .q(low_priority_channel_count)
    );

    // entry size of the port arbitration table
    field_reg #(
        .W(vc_cap_pkg::ESIZE_W),
        .RST(vc_cap_pkg::ESIZE_RST)
    ) u_esize (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(wr_cap_one_lock),
        .wr_data(req.wdata[vc_cap_pkg::ESIZE_LSB +: vc_cap_pkg::ESIZE_W]),
        .q(arb_table_entry_size)
    );

    // ----------------------------------------
    // control word fields
    // ----------------------------------------
    logic [0:0] load_channel_arb_table;
    logic [2:0] sel_q;

    // load bit is stored only, nothing is loaded
    field_reg #(
        .W(1),
        .RST(vc_cap_pkg::LOAD_RST)
    ) u_load (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(wr_ctl),
        .wr_data(req.wdata[vc_cap_pkg::LOAD_BIT +: 1]),
        .q(load_channel_arb_table)
    );

    // select field is stored only, there is one channel to pick
    field_reg #(
        .W(vc_cap_pkg::SEL_W),
        .RST(vc_cap_pkg::SEL_RST)
    ) u_sel (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(wr_ctl),
        .wr_data(req.wdata[vc_cap_pkg::SEL_LSB +: vc_cap_pkg::SEL_W]),
        .q(sel_q)
    );

    // ----------------------------------------
    // resource 0 capability fields
    // ----------------------------------------
    logic [7:0] port_arb_capability;
    logic [7:0] port_arb_table_offset;

    // arbitration capability, bit 0 hardware fixed
    field_reg #(
        .W(vc_cap_pkg::PARB_W),
        .RST(vc_cap_pkg::PARB_RST)
    ) u_parb (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(wr_vcr0_lock),
        .wr_data(req.wdata[vc_cap_pkg::PARB_LSB +: vc_cap_pkg::PARB_W]),
        .q(port_arb_capability)
    );

    // port table location in 16-byte units from the structure base
    field_reg #(
        .W(vc_cap_pkg::PATOFF_W),
        .RST(vc_cap_pkg::PATOFF_RST)
    ) u_patoff (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(wr_vcr0_lock),
        .wr_data(req.wdata[vc_cap_pkg::PATOFF_LSB +: vc_cap_pkg::PATOFF_W]),
        .q(port_arb_table_offset)
    );

    // ----------------------------------------
    // read word assembly
    // ----------------------------------------
    logic [31:0] cap_one_word;
    logic [31:0] cap_two_word;
    logic [31:0] ctl_word;
    logic [31:0] sts_word;
    logic [31:0] vcr0_word;
    logic [31:0] rd_word;

    // place stored fields, everything else stays zero
    always_comb begin
        cap_one_word = 32'h0000_0000;
        cap_one_word[vc_cap_pkg::EXTRA_LSB +: vc_cap_pkg::EXTRA_W] = extra_channel_count;
        cap_one_word[vc_cap_pkg::LOWPRI_LSB +: vc_cap_pkg::LOWPRI_W] = low_priority_channel_count;
        cap_one_word[vc_cap_pkg::TBASE_LSB +: vc_cap_pkg::TBASE_W] = 2'h0;
        cap_one_word[vc_cap_pkg::ESIZE_LSB +: vc_cap_pkg::ESIZE_W] = arb_table_entry_size;
        cap_two_word = 32'h0000_0000;
        cap_two_word[vc_cap_pkg::CARB_CAP_LSB +: vc_cap_pkg::CARB_CAP_W] = 8'h00;
        cap_two_word[vc_cap_pkg::CARB_OFS_LSB +: vc_cap_pkg::CARB_OFS_W] = 8'h00;
        ctl_word = 32'h0000_0000;
        ctl_word[vc_cap_pkg::LOAD_BIT] = load_channel_arb_table[0];
        ctl_word[vc_cap_pkg::SEL_LSB +: vc_cap_pkg::SEL_W] = sel_q;
        sts_word = 32'h0000_0000;
        sts_word[vc_cap_pkg::TSTAT_BIT] = 1'b0;
        vcr0_word = 32'h0000_0000;
        vcr0_word[vc_cap_pkg::PARB_LSB +: vc_cap_pkg::PARB_W] = port_arb_capability;
        vcr0_word[vc_cap_pkg::SNOOP_BIT] = 1'b0;
        vcr0_word[vc_cap_pkg::MAX_TIME_SLOTS_LSB +: vc_cap_pkg::MAX_TIME_SLOTS_W] = 7'h00;
        vcr0_word[vc_cap_pkg::PATOFF_LSB +: vc_cap_pkg::PATOFF_W] = port_arb_table_offset;
    end

    // select the addressed word, unmapped reads give zero
    assign rd_word = hit_cap_one ? cap_one_word :
                     hit_cap_two ? cap_two_word :
                     hit_ctl ? ctl_word :
                     hit_sts ? sts_word :
                     hit_vcr0 ? vcr0_word : 32'h0000_0000;

    // ----------------------------------------
    // read data register and exported fields
    // ----------------------------------------
    read_port u_read (
        .clk_sys(clk_sys),
        .reset(reset),
        .rd_en(req.rd),
        .rd_word(rd_word),
        .rdata(rdata)
    );

    // table size and place go to the table logic of the port
    assign arb_info.table_offset = port_arb_table_offset;
    assign arb_info.entry_size = arb_table_entry_size;
    assign arb_info.capability = port_arb_capability;
    assign channel_arb_select = sel_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_extra_guard;
        @(posedge clk_sys) disable iff (reset)
        (req.wr && !req.priv) |=> $stable(extra_channel_count) && $stable(low_priority_channel_count);
    endproperty
    a_extra_guard: assert property (p_extra_guard)
        else $error("channel count changed on an ordinary write");

    property p_extra_read;
        @(posedge clk_sys) disable iff (reset)
        (req.rd && hit_cap_one) |=> (rdata[2:0] == $past(extra_channel_count)) && (rdata[6:4] == $past(low_priority_channel_count));
    endproperty
    a_extra_read: assert property (p_extra_read)
        else $error("channel counts read back wrong");

    property p_tbase_zero;
        @(posedge clk_sys) disable iff (reset)
        (req.rd && hit_cap_one) |=> (rdata[9:8] == 2'h0) && (rdata[31:12] == 20'h00000) && !rdata[3] && !rdata[7];
    endproperty
    a_tbase_zero: assert property (p_tbase_zero)
        else $error("time base or reserved bits not zero");

    property p_esize_reset;
        @(posedge clk_sys) disable iff (reset)
        $fell(reset) |-> (arb_table_entry_size == vc_cap_pkg::ESIZE_RST) && (extra_channel_count == vc_cap_pkg::EXTRA_RST);
    endproperty
    a_esize_reset: assert property (p_esize_reset)
        else $error("entry size not 4-bit after reset");

    property p_esize_load;
        @(posedge clk_sys) disable iff (reset)
        (req.wr && req.priv && hit_cap_one) |=> arb_table_entry_size == $past(req.wdata[11:10]);
    endproperty
    a_esize_load: assert property (p_esize_load)
        else $error("privileged write did not load entry size");

    property p_cap_two_zero;
        @(posedge clk_sys) disable iff (reset)
        (req.rd && hit_cap_two) |=> (rdata[7:0] == 8'h00) ##0 (rdata == 32'h0000_0000);
    endproperty
    a_cap_two_zero: assert property (p_cap_two_zero)
        else $error("second capability word not zero");

    property p_carb_ofs_zero;
        @(posedge clk_sys) disable iff (reset)
        (req.rd && hit_cap_two) |=> rdata[31:24] == 8'h00;
    endproperty
    a_carb_ofs_zero: assert property (p_carb_ofs_zero)
        else $error("channel table offset not zero");

    property p_load_bit;
        @(posedge clk_sys) disable iff (reset)
        (req.wr && hit_ctl) ##1 (req.rd && hit_ctl) |=> rdata[0] == $past(req.wdata[0], 2);
    endproperty
    a_load_bit: assert property (p_load_bit)
        else $error("load bit did not read back");

    property p_sel_store;
        @(posedge clk_sys) disable iff (reset)
        (req.wr && hit_ctl) |=> (channel_arb_select == $past(req.wdata[3:1])) && $stable(arb_info);
    endproperty
    a_sel_store: assert property (p_sel_store)
        else $error("select not stored or leaked into arbitration");

    property p_sts_zero;
        @(posedge clk_sys) disable iff (reset)
        (req.rd && hit_sts) |=> rdata == 32'h0000_0000;
    endproperty
    a_sts_zero: assert property (p_sts_zero)
        else $error("status word not zero");

    property p_parb_reset;
        @(posedge clk_sys) disable iff (reset)
        $fell(reset) |-> (arb_info.capability == vc_cap_pkg::PARB_RST) && (arb_info.table_offset == vc_cap_pkg::PATOFF_RST);
    endproperty
    a_parb_reset: assert property (p_parb_reset)
        else $error("port arbitration fields wrong after reset");

    property p_vcr0_read;
        @(posedge clk_sys) disable iff (reset)
        (req.rd && hit_vcr0) |=> !rdata[15] && (rdata[31:24] == $past(port_arb_table_offset));
    endproperty
    a_vcr0_read: assert property (p_vcr0_read)
        else $error("snoop bit set or offset read wrong");

    property p_max_time_slots_zero;
        @(posedge clk_sys) disable iff (reset)
        (req.rd && hit_vcr0) |=> (rdata[22:16] == 7'h00) && (rdata[14:8] == 7'h00) && !rdata[23];
    endproperty
    a_max_time_slots_zero: assert property (p_max_time_slots_zero)
        else $error("time slots or reserved bits not zero");

    property p_patoff_lock;
        @(posedge clk_sys) disable iff (reset)
        (req.wr && !req.priv && hit_vcr0) |=> $stable(port_arb_table_offset) && $stable(port_arb_capability);
    endproperty
    a_patoff_lock: assert property (p_patoff_lock)
        else $error("table offset changed on an ordinary write");

    property p_unmapped;
        @(posedge clk_sys) disable iff (reset)
        ((req.rd && !hit_any) or !req.rd) |=> rdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("read data outside a mapped read not zero");

    // entry size is lockable like the channel counts
    property p_esize_guard;
        @(posedge clk_sys) disable iff (reset)
        (req.wr && !req.priv) |=> $stable(arb_table_entry_size);
    endproperty
    a_esize_guard: assert property (p_esize_guard)
        else $error("entry size changed on an ordinary write");

    // control word gives back the stored select and zero above it
    property p_ctl_read;
        @(posedge clk_sys) disable iff (reset)
        (req.rd && hit_ctl) |=> (rdata[3:1] == $past(sel_q)) && (rdata[31:4] == 28'h0000000);
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("control word read back wrong");

    // a privileged write loads both port arbitration fields
    property p_vcr0_load;
        @(posedge clk_sys) disable iff (reset)
        (req.wr && req.priv && hit_vcr0) |=> (port_arb_capability == $past(req.wdata[7:0]))
            && (port_arb_table_offset == $past(req.wdata[31:24]));
    endproperty
    a_vcr0_load: assert property (p_vcr0_load)
        else $error("privileged write did not load port arbitration fields");

endmodule : vc_capability_regs

// [tb/vc_capability_regs_tb.sv]
// self-checking bench for the virtual channel capability register bank
// assumes the design files are compiled first and the bench drives every port itself
`timescale 1ns/10ps
module vc_capability_regs_tb;
    // ----------------------------------------
    // clock, reset and design ports
    // ----------------------------------------
    logic clk_sys;
    logic reset;
    vc_cap_pkg::cfg_req_t req;
    logic [31:0] rdata;
    vc_cap_pkg::arb_info_t arb_info;
    logic [2:0] channel_arb_select;
    int num_errors;
    int checks;
    logic [2:0] m_extra, m_lowpri, m_sel;
    logic [1:0] m_esize;
    logic [7:0] m_parb, m_patoff;
    logic m_load;
    logic [11:0] addr_tab [8] = '{12'h204, 12'h208, 12'h20c, 12'h20e, 12'h210, 12'h200, 12'h214, 12'h20d};

    vc_capability_regs u_vc_capability_regs (
        .clk_sys(clk_sys),
        .reset(reset),
        .req(req),
        .rdata(rdata),
        .arb_info(arb_info),
        .channel_arb_select(channel_arb_select)
    );

    // free-running 100 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // expectation model
    // ----------------------------------------
    // word that a read of an address should return
    function automatic logic [31:0] exp_word(input logic [11:0] a);
        case (a)
            vc_cap_pkg::OFS_CAP_ONE: exp_word = {20'h0, m_esize, 2'h0, 1'b0, m_lowpri, 1'b0, m_extra};
            vc_cap_pkg::OFS_CTL: exp_word = {28'h0, m_sel, m_load};
            vc_cap_pkg::OFS_VCR0: exp_word = {m_patoff, 16'h0, m_parb};
            default: exp_word = 32'h0;
        endcase
    endfunction : exp_word

    // lockable fields follow only privileged writes, control fields any write
    task automatic model_wr(input logic [11:0] a, input logic [31:0] d, input logic p);
        if (a == vc_cap_pkg::OFS_CAP_ONE && p) begin
            m_extra = d[2:0];
            m_lowpri = d[6:4];
            m_esize = d[11:10];
        end
        if (a == vc_cap_pkg::OFS_VCR0 && p) begin
            m_parb = d[7:0];
            m_patoff = d[31:24];
        end
        if (a == vc_cap_pkg::OFS_CTL) begin
            m_sel = d[3:1];
            m_load = d[0];
        end
    endtask : model_wr

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic drive(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d, input logic p);
        @(posedge clk_sys);
        req <= vc_cap_pkg::cfg_req_t'{a, d, w, r, p};
    endtask : drive

    // read, compare the answer cycle, then see the data drop back to zero
    task automatic rd_chk(input logic [11:0] a);
        drive(1'b0, 1'b1, a, 32'h0, 1'b0);
        drive(1'b0, 1'b0, 12'h0, 32'h0, 1'b0);
        #1;
        check($sformatf("rdata_%h", a), rdata, exp_word(a)); // read answer
        @(posedge clk_sys);
        #1;
        check("rdata_idle", rdata, 32'h0); // data stands one cycle
    endtask : rd_chk

    task automatic chk_outputs();
        check("arb_info", {14'h0, arb_info}, {14'h0, m_patoff, m_esize, m_parb}); // table info
        check("channel_arb_select", {29'h0, channel_arb_select}, {29'h0, m_sel}); // stored select
    endtask : chk_outputs

    // write immediately followed by a read of the same address
    task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic p);
        drive(1'b1, 1'b0, a, d, p);
        model_wr(a, d, p);
        rd_chk(a);
        chk_outputs();
    endtask : wr_rd

    task automatic do_reset();
        int i;
        @(posedge clk_sys);
        req <= '0;
        reset <= 1'b1;
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        m_extra = vc_cap_pkg::EXTRA_RST;
        m_lowpri = vc_cap_pkg::LOWPRI_RST;
        m_esize = vc_cap_pkg::ESIZE_RST;
        m_parb = vc_cap_pkg::PARB_RST;
        m_patoff = vc_cap_pkg::PATOFF_RST;
        m_load = vc_cap_pkg::LOAD_RST;
        m_sel = vc_cap_pkg::SEL_RST;
        @(posedge clk_sys);
        #1;
        chk_outputs(); // reset values
        for (i = 0; i < 8; i++) begin
            rd_chk(addr_tab[i]); // reset words
        end
    endtask : do_reset

    task automatic final_report();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int i;
        logic [11:0] a;
        reset = 1'b1;
        req = '0;
        num_errors = 0;
        checks = 0;
        void'($urandom(32'h3f83));
        do_reset();
        // every entry size code under a privileged write
        for (i = 0; i < 4; i++) begin
            wr_rd(vc_cap_pkg::OFS_CAP_ONE, 32'(i) << 10, 1'b1); // size codes
        end
        wr_rd(vc_cap_pkg::OFS_CAP_ONE, 32'hffffffff, 1'b0); // ordinary write refused
        wr_rd(vc_cap_pkg::OFS_CAP_ONE, 32'hffffffff, 1'b1); // fixed zero bits
        wr_rd(vc_cap_pkg::OFS_CAP_TWO, 32'hffffffff, 1'b1); // read-only word
        wr_rd(vc_cap_pkg::OFS_CTL, 32'hffffffff, 1'b0); // control writable
        wr_rd(vc_cap_pkg::OFS_STS, 32'hffffffff, 1'b1); // status stays zero
        wr_rd(vc_cap_pkg::OFS_VCR0, 32'hffffffff, 1'b0); // ordinary write refused
        wr_rd(vc_cap_pkg::OFS_VCR0, 32'hffffffff, 1'b1); // fixed zero bits
        wr_rd(vc_cap_pkg::OFS_CTL, 32'h0000000e, 1'b0); // select only
        // random traffic over mapped and unmapped places
        for (i = 0; i < 120; i++) begin
            a = ($urandom % 4 == 0) ? 12'($urandom) : addr_tab[$urandom % 8];
            wr_rd(a, $urandom, 1'($urandom)); // random access
        end
        do_reset(); // second reset at the end of the run
        final_report();
    end

    // watchdog against a hung sequence
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        final_report();
    end
endmodule : vc_capability_regs_tb
